// file: hdl/ess_save_seq.sv
// EEPROM save sequence interpreter with its EEPROM write FIFO.
`timescale 1ns/1ps

module ess_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 8
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [WIDTH-1:0] i_data,
	output logic o_valid,
	input wire logic i_ready,
	output logic [WIDTH-1:0] o_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [AW:0] cnt_reg;
	wire logic do_wr = i_valid && o_ready;
	wire logic do_rd = o_valid && i_ready;
	wire logic [AW-1:0] wr_next = (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
	wire logic [AW-1:0] rd_next = (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;

	assign o_ready = (cnt_reg != (AW+1)'(DEPTH));
	assign o_valid = (cnt_reg != '0);
	assign o_data = mem[rd_reg];

	always_ff @(posedge i_clk) begin
		if (do_wr) begin
			mem[wr_reg] <= i_data;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end else begin
			if (do_wr) begin
				wr_reg <= wr_next;
			end
			if (do_rd) begin
				rd_reg <= rd_next;
			end
			cnt_reg <= cnt_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
		end
	end
endmodule

// What this block does
// - Each scratchpad count byte N commands a transfer of N plus one bytes.
// - The two bytes after the count give the register-map start address.
// - The count byte is written to EEPROM, then the pointer advances.
// - Both start-address bytes are written, pointer advances by two.
// - N plus one map bytes are copied from the start address onward.
// - Exactly one checksum byte follows each data block in EEPROM.
// - Filter entry resets to count 0x17, address 0x0800, 24 bytes.
// - Common control entry resets to 0x0e, 0x0a00, 15 bytes, pointer plus 19.
// - Loop B divider entry resets to 0x33, 0x0540; count decodes as 52 bytes.
module ess_save_seq #(
	parameter int FIFO_DEPTH = 8
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [11:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	output logic o_map_rd,
	output logic [15:0] o_map_addr,
	input wire logic [7:0] i_map_data,
	output logic o_ee_valid,
	input wire logic i_ee_ready,
	output logic [15:0] o_ee_addr,
	output logic [7:0] o_ee_data,
	output logic o_busy
);
	ess_pkg::ess_state_t state_reg;
	ess_pkg::ess_state_t state_next;
	logic [7:0] pad_reg [0:8];
	logic [1:0] entry_reg;
	logic [15:0] ptr_reg;
	logic [15:0] src_reg;
	logic [7:0] left_reg;
	logic [7:0] data_reg;
	logic data_ok_reg;
	logic [7:0] sum_reg;
	logic done_reg;
	logic [7:0] rdata_reg;
	ess_pkg::ess_ee_word_t push_word;
	logic fifo_ready;

	// Scratchpad byte selection for the current entry.
	wire logic [3:0] ent_base = {1'b0, entry_reg, 1'b0} + {2'b00, entry_reg};
	wire logic [7:0] cur_cnt = pad_reg[ent_base];
	wire logic [7:0] cur_hi = pad_reg[ent_base + 4'h1];
	wire logic [7:0] cur_lo = pad_reg[ent_base + 4'h2];
	wire logic last_entry = (entry_reg == ess_pkg::ESS_LAST_ENTRY);

	// Register decode.
	wire logic [11:0] pad_off = i_addr - ess_pkg::ESS_OFS_PAD_BASE;
	wire logic hit_pad = (i_addr >= ess_pkg::ESS_OFS_PAD_BASE) &&
		(pad_off < {8'h00, ess_pkg::ESS_PAD_BYTES});
	wire logic hit_ctrl = (i_addr == ess_pkg::ESS_OFS_CTRL);
	wire logic hit_stat = (i_addr == ess_pkg::ESS_OFS_STAT);
	wire logic hit_plo = (i_addr == ess_pkg::ESS_OFS_PTR_LO);
	wire logic hit_phi = (i_addr == ess_pkg::ESS_OFS_PTR_HI);
	// Scratchpad writes are refused while a save runs so an entry cannot change mid-block.
	wire logic pad_we = i_wr && hit_pad && !o_busy;
	wire logic start = i_wr && hit_ctrl && i_wdata[ess_pkg::ESS_CTRL_START_BIT] && !o_busy;
	wire logic [7:0] stat_val = {6'h00, done_reg, o_busy};
	wire logic [7:0] rd_val = hit_pad ? pad_reg[pad_off[3:0]] :
		hit_stat ? stat_val :
		hit_plo ? ptr_reg[7:0] :
		hit_phi ? ptr_reg[15:8] : 8'h00;

	// EEPROM word selection and push qualification.
	wire logic emit = (state_reg == ess_pkg::ESS_INSTR) || (state_reg == ess_pkg::ESS_AHI) ||
		(state_reg == ess_pkg::ESS_ALO) || (state_reg == ess_pkg::ESS_CSUM) ||
		((state_reg == ess_pkg::ESS_RDDAT) && data_ok_reg);
	wire logic push = emit && fifo_ready;
	wire logic [7:0] csum = 8'h00 - sum_reg;
	wire logic [7:0] push_data = (state_reg == ess_pkg::ESS_INSTR) ? cur_cnt :
		(state_reg == ess_pkg::ESS_AHI) ? cur_hi :
		(state_reg == ess_pkg::ESS_ALO) ? cur_lo :
		(state_reg == ess_pkg::ESS_CSUM) ? csum : data_reg;
	assign push_word.addr = ptr_reg;
	assign push_word.data = push_data;

	assign o_busy = (state_reg != ess_pkg::ESS_IDLE);
	assign o_map_rd = (state_reg == ess_pkg::ESS_RDREQ);
	assign o_map_addr = src_reg;
	assign o_rdata = rdata_reg;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ess_pkg::ESS_IDLE: begin
				if (start) begin
					state_next = ess_pkg::ESS_INSTR;
				end
			end
			ess_pkg::ESS_INSTR: begin
				if (push) begin
					state_next = ess_pkg::ESS_AHI;
				end
			end
			ess_pkg::ESS_AHI: begin
				if (push) begin
					state_next = ess_pkg::ESS_ALO;
				end
			end
			ess_pkg::ESS_ALO: begin
				if (push) begin
					state_next = ess_pkg::ESS_RDREQ;
				end
			end
			ess_pkg::ESS_RDREQ: begin
				state_next = ess_pkg::ESS_RDDAT;
			end
			ess_pkg::ESS_RDDAT: begin
				if (push) begin
					state_next = (left_reg == 8'h00) ? ess_pkg::ESS_CSUM : ess_pkg::ESS_RDREQ;
				end
			end
			ess_pkg::ESS_CSUM: begin
				if (push) begin
					state_next = last_entry ? ess_pkg::ESS_IDLE : ess_pkg::ESS_INSTR;
				end
			end
			default: begin
				state_next = ess_pkg::ESS_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			state_reg <= ess_pkg::ESS_IDLE;
			rdata_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			rdata_reg <= i_rd ? rd_val : 8'h00;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			pad_reg[0] <= ess_pkg::ESS_RST_B_CNT;
			pad_reg[1] <= ess_pkg::ESS_RST_B_ADDR_A;
			pad_reg[2] <= ess_pkg::ESS_RST_B_ADDR_B;
			pad_reg[3] <= ess_pkg::ESS_RST_F_CNT;
			pad_reg[4] <= ess_pkg::ESS_RST_F_ADDR_A;
			pad_reg[5] <= ess_pkg::ESS_RST_F_ADDR_B;
			pad_reg[6] <= ess_pkg::ESS_RST_C_CNT;
			pad_reg[7] <= ess_pkg::ESS_RST_C_ADDR_A;
			pad_reg[8] <= ess_pkg::ESS_RST_C_ADDR_B;
		end else if (pad_we) begin
			pad_reg[pad_off[3:0]] <= i_wdata;
		end
	end

	// The done flag is set by the last checksum; a start in the same cycle cannot occur.
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			done_reg <= 1'b0;
		end else if (push && (state_reg == ess_pkg::ESS_CSUM) && last_entry) begin
			done_reg <= 1'b1;
		end else if (start) begin
			done_reg <= 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			entry_reg <= 2'h0;
			ptr_reg <= ess_pkg::ESS_RST_EE_PTR;
			src_reg <= 16'h0000;
			left_reg <= 8'h00;
			data_reg <= 8'h00;
			data_ok_reg <= 1'b0;
			sum_reg <= 8'h00;
		end else begin
			if (start) begin
				entry_reg <= 2'h0;
				ptr_reg <= ess_pkg::ESS_RST_EE_PTR;
			end
			if (push) begin
				ptr_reg <= ptr_reg + 16'h0001;
			end
			if (push && (state_reg == ess_pkg::ESS_INSTR)) begin
				left_reg <= cur_cnt;
				sum_reg <= 8'h00;
			end
			if (push && (state_reg == ess_pkg::ESS_ALO)) begin
				src_reg <= {cur_hi, cur_lo};
			end
			// The map answers one cycle after the read strobe; hold that byte while the FIFO stalls.
			if ((state_reg == ess_pkg::ESS_RDDAT) && !data_ok_reg) begin
				data_reg <= i_map_data;
				data_ok_reg <= 1'b1;
			end
			if (push && (state_reg == ess_pkg::ESS_RDDAT)) begin
				data_ok_reg <= 1'b0;
				src_reg <= src_reg + 16'h0001;
				left_reg <= left_reg - 8'h01;
				sum_reg <= sum_reg + data_reg;
			end
			if (push && (state_reg == ess_pkg::ESS_CSUM) && !last_entry) begin
				entry_reg <= entry_reg + 2'h1;
			end
		end
	end

	ess_fifo #(
		.WIDTH($bits(ess_pkg::ess_ee_word_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_valid(emit),
		.o_ready(fifo_ready),
		.i_data(push_word),
		.o_valid(o_ee_valid),
		.i_ready(i_ee_ready),
		.o_data({o_ee_addr, o_ee_data})
	);

	// Helper: data bytes pushed in the current block.
	logic [8:0] blk_cnt_reg;
	always_ff @(posedge i_clk) begin
		if (!i_rst_b || (state_reg == ess_pkg::ESS_INSTR)) begin
			blk_cnt_reg <= 9'h000;
		end else if (push && (state_reg == ess_pkg::ESS_RDDAT)) begin
			blk_cnt_reg <= blk_cnt_reg + 9'h001;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	a_block_length: assert property (
		push && (state_reg == ess_pkg::ESS_CSUM) |-> blk_cnt_reg == ({1'b0, cur_cnt} + 9'h001))
		else $error("Data block length differs from count plus one.");
	a_start_addr: assert property (
		push && (state_reg == ess_pkg::ESS_ALO) |=> (src_reg == {$past(cur_hi), $past(cur_lo)}))
		else $error("Start address not taken from the two address bytes.");
	a_instr_write: assert property (
		push && (state_reg == ess_pkg::ESS_INSTR) |-> push_word.data == cur_cnt
		##1 ptr_reg == $past(ptr_reg) + 16'h0001)
		else $error("Count byte not written or pointer not advanced.");
	// The pair is checked as two single steps, so a long FIFO stall cannot outrun a repetition.
	a_addr_pair: assert property (
		push && (state_reg == ess_pkg::ESS_AHI) |-> push_word.data == cur_hi
		##1 (state_reg == ess_pkg::ESS_ALO) && (ptr_reg == $past(ptr_reg) + 16'h0001))
		else $error("Address high byte not written or pointer not advanced.");
	a_addr_low: assert property (
		push && (state_reg == ess_pkg::ESS_ALO) |-> push_word.data == cur_lo
		##1 (state_reg == ess_pkg::ESS_RDREQ) && (ptr_reg == $past(ptr_reg) + 16'h0001))
		else $error("Address low byte not written or pointer not advanced.");
	a_map_source: assert property (
		o_map_rd |-> o_map_addr == {cur_hi, cur_lo} + {7'h00, blk_cnt_reg})
		else $error("Register map read address out of sequence.");
	a_one_csum: assert property (
		push && (state_reg == ess_pkg::ESS_CSUM) |=> state_reg != ess_pkg::ESS_CSUM)
		else $error("More than one checksum byte written.");
	a_csum_follow: assert property (
		push && (state_reg == ess_pkg::ESS_RDDAT) && (left_reg == 8'h00)
		|=> state_reg == ess_pkg::ESS_CSUM)
		else $error("Data block not followed by checksum.");
	a_filter_rst: assert property (disable iff (1'b0)
		i_rst_b && $past(!i_rst_b) |-> pad_reg[3] == 8'h17 && {pad_reg[4], pad_reg[5]} == 16'h0800)
		else $error("Filter entry reset value wrong.");
	a_common_rst: assert property (disable iff (1'b0)
		i_rst_b && $past(!i_rst_b) |-> pad_reg[6] == 8'h0e && {pad_reg[7], pad_reg[8]} == 16'h0a00)
		else $error("Common control entry reset value wrong.");
	a_loop_b_rst: assert property (disable iff (1'b0)
		i_rst_b && $past(!i_rst_b) |-> pad_reg[0] == 8'h33 && {pad_reg[1], pad_reg[2]} == 16'h0540)
		else $error("Loop B divider entry reset value wrong.");
	a_entry_order: assert property (
		// A restart rewinds the entry index from idle, which is not a step.
		o_busy && $past(o_busy) && $changed(entry_reg) |-> entry_reg == $past(entry_reg) + 2'h1 &&
		$past(state_reg) == ess_pkg::ESS_CSUM)
		else $error("Entry order broken or entry left before checksum.");

	c_save_done: cover property (push && (state_reg == ess_pkg::ESS_CSUM) && last_entry);
	c_fifo_stall: cover property (emit && !fifo_ready);
	c_restart: cover property (done_reg && start);
endmodule

// file: inc/ess_pkg.sv
// Package for the EEPROM save sequence interpreter: offsets, reset values, types.
package ess_pkg;
	localparam logic [11:0] ESS_OFS_PAD_BASE = 12'he36;
	localparam logic [11:0] ESS_OFS_B_CNT = 12'he36;
	localparam logic [11:0] ESS_OFS_B_ADDR_A = 12'he37;
	localparam logic [11:0] ESS_OFS_B_ADDR_B = 12'he38;
	localparam logic [11:0] ESS_OFS_F_CNT = 12'he39;
	localparam logic [11:0] ESS_OFS_F_ADDR_A = 12'he3a;
	localparam logic [11:0] ESS_OFS_F_ADDR_B = 12'he3b;
	localparam logic [11:0] ESS_OFS_C_CNT = 12'he3c;
	localparam logic [11:0] ESS_OFS_C_ADDR_A = 12'he3d;
	localparam logic [11:0] ESS_OFS_C_ADDR_B = 12'he3e;
	localparam logic [11:0] ESS_OFS_CTRL = 12'he50;
	localparam logic [11:0] ESS_OFS_STAT = 12'he51;
	localparam logic [11:0] ESS_OFS_PTR_LO = 12'he52;
	localparam logic [11:0] ESS_OFS_PTR_HI = 12'he53;
	localparam int ESS_CTRL_START_BIT = 0;
	localparam int ESS_STAT_BUSY_BIT = 0;
	localparam int ESS_STAT_DONE_BIT = 1;
	localparam logic [3:0] ESS_PAD_BYTES = 4'h9;
	localparam logic [1:0] ESS_LAST_ENTRY = 2'h2;
	localparam logic [7:0] ESS_RST_B_CNT = 8'h33;
	localparam logic [7:0] ESS_RST_B_ADDR_A = 8'h05;
	localparam logic [7:0] ESS_RST_B_ADDR_B = 8'h40;
	localparam logic [7:0] ESS_RST_F_CNT = 8'h17;
	localparam logic [7:0] ESS_RST_F_ADDR_A = 8'h08;
	localparam logic [7:0] ESS_RST_F_ADDR_B = 8'h00;
	localparam logic [7:0] ESS_RST_C_CNT = 8'h0e;
	localparam logic [7:0] ESS_RST_C_ADDR_A = 8'h0a;
	localparam logic [7:0] ESS_RST_C_ADDR_B = 8'h00;
	localparam logic [15:0] ESS_RST_EE_PTR = 16'h0000;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] data;
	} ess_ee_word_t;

	typedef enum logic [6:0] {
		ESS_IDLE = 7'h01,
		ESS_INSTR = 7'h02,
		ESS_AHI = 7'h04,
		ESS_ALO = 7'h08,
		ESS_RDREQ = 7'h10,
		ESS_RDDAT = 7'h20,
		ESS_CSUM = 7'h40
	} ess_state_t;
endpackage

// file: test/ess_far_model.sv
// Far-side model: register map answering reads, EEPROM sink taking bytes.
`timescale 1ns/1ps
module ess_far_model (
	input wire logic i_clk,
	input wire logic i_slow,
	input wire logic i_map_rd,
	input wire logic [15:0] i_map_addr,
	output logic [7:0] o_map_data,
	output logic o_ee_ready
);
	initial begin
		o_map_data = 8'h00;
		o_ee_ready = 1'b0;
	end
	// Map data is valid only in the cycle after a read; it toggles otherwise so stale use shows.
	always @(posedge i_clk) begin
		if (i_map_rd === 1'b1) begin
			o_map_data <= i_map_addr[7:0] ^ i_map_addr[15:8] ^ 8'h3c;
		end else begin
			o_map_data <= ~o_map_data;
		end
		o_ee_ready <= i_slow ? ($urandom_range(3) == 0) : 1'b1;
	end
endmodule

// file: test/tb_top.sv
// Self-checking testbench for the EEPROM save sequence interpreter.
`timescale 1ns/1ps
module tb_top;
	logic i_clk = 1'b0;
	logic i_rst_b = 1'b0;
	logic [11:0] i_addr = 12'h000;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic slow = 1'b0;
	logic [7:0] o_rdata, i_map_data, o_ee_data, rv;
	logic o_map_rd, o_ee_valid, i_ee_ready, o_busy;
	logic [15:0] o_map_addr, o_ee_addr, total;
	logic [7:0] cnt [3];
	logic [15:0] sa [3];
	logic [7:0] dflt [9] = '{8'h33, 8'h05, 8'h40, 8'h17, 8'h08, 8'h00, 8'h0e, 8'h0a, 8'h00};
	int miscompares = 0;
	int cmp_count = 0;
	int cycles = 0;
	ess_pkg::ess_ee_word_t exp_q[$];
	always #4 i_clk = ~i_clk;

	ess_save_seq #(.FIFO_DEPTH(8)) ess_save_seq_i (.i_clk(i_clk), .i_rst_b(i_rst_b),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.o_map_rd(o_map_rd), .o_map_addr(o_map_addr), .i_map_data(i_map_data),
		.o_ee_valid(o_ee_valid), .i_ee_ready(i_ee_ready), .o_ee_addr(o_ee_addr),
		.o_ee_data(o_ee_data), .o_busy(o_busy));
	ess_far_model ess_far_model_i (.i_clk(i_clk), .i_slow(slow), .i_map_rd(o_map_rd),
		.i_map_addr(o_map_addr), .o_map_data(i_map_data), .o_ee_ready(i_ee_ready));

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		rv = o_rdata;
	endtask
	// Expected stream: count, address high, address low, N+1 map bytes, checksum.
	task automatic build();
		logic [15:0] p;
		logic [7:0] sum;
		logic [7:0] d;
		logic [15:0] ma;
		p = 16'h0000;
		for (int e = 0; e < 3; e++) begin
			exp_q.push_back({p, cnt[e]});
			exp_q.push_back({p + 16'h0001, sa[e][15:8]});
			exp_q.push_back({p + 16'h0002, sa[e][7:0]});
			p = p + 16'h0003;
			sum = 8'h00;
			for (int i = 0; i <= int'(cnt[e]); i++) begin
				ma = sa[e] + 16'(i);
				d = ma[7:0] ^ ma[15:8] ^ 8'h3c;
				exp_q.push_back({p, d});
				sum = sum + d;
				p = p + 16'h0001;
			end
			exp_q.push_back({p, 8'h00 - sum});
			p = p + 16'h0001;
		end
		total = p;
	endtask
	// The scratchpad poke lands while busy, so it must leave the filter count alone.
	task automatic run(input logic [7:0] poke);
		int k;
		build();
		wr(ess_pkg::ESS_OFS_CTRL, 8'h01);
		wr(ess_pkg::ESS_OFS_F_CNT, poke);
		k = 0;
		while (k < 20000 && (o_busy !== 1'b0 || exp_q.size() != 0)) begin
			@(posedge i_clk);
			k++;
		end
		check(24'(exp_q.size()), 24'h000000);
		rd(ess_pkg::ESS_OFS_PTR_LO);
		check(24'(rv), 24'(total[7:0]));
		rd(ess_pkg::ESS_OFS_PTR_HI);
		check(24'(rv), 24'(total[15:8]));
		rd(ess_pkg::ESS_OFS_STAT);
		check(24'(rv[1:0]), 24'h000002);
		rd(ess_pkg::ESS_OFS_F_CNT);
		check(24'(rv), 24'(cnt[1]));
	endtask

	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 60000) begin
			miscompares++;
			$display("BAD t=%0t timeout", $time);
			report_and_stop();
		end
		if (i_rst_b && o_ee_valid === 1'b1 && i_ee_ready === 1'b1) begin
			if (exp_q.size() == 0) begin
				miscompares++;
				$display("BAD t=%0t unexpected EEPROM word", $time);
			end else begin
				check({o_ee_addr, o_ee_data}, exp_q.pop_front());
			end
		end
	end

	initial begin
		void'($urandom(32'h692ad97d));
		repeat (8) @(posedge i_clk);
		i_rst_b <= 1'b1;
		for (int r = 0; r < 9; r++) begin
			rd(ess_pkg::ESS_OFS_PAD_BASE + 12'(r));
			check(24'(rv), 24'(dflt[r]));
		end
		wr(12'h123, 8'h5a);
		rd(12'h123);
		check(24'(rv), 24'h000000);
		cnt = '{8'h33, 8'h17, 8'h0e};
		sa = '{16'h0540, 16'h0800, 16'h0a00};
		run(8'h01);
		slow <= 1'b1;
		for (int pass = 0; pass < 2; pass++) begin
			for (int e = 0; e < 3; e++) begin
				cnt[e] = 8'($urandom_range(40));
				sa[e] = 16'($urandom);
			end
			if (pass == 1) begin
				cnt[0] = 8'h00;
				cnt[1] = 8'hff;
			end
			for (int e = 0; e < 3; e++) begin
				wr(ess_pkg::ESS_OFS_PAD_BASE + 12'(3 * e), cnt[e]);
				wr(ess_pkg::ESS_OFS_PAD_BASE + 12'(3 * e + 1), sa[e][15:8]);
				wr(ess_pkg::ESS_OFS_PAD_BASE + 12'(3 * e + 2), sa[e][7:0]);
			end
			run(8'(~cnt[1]));
		end
		report_and_stop();
	end
endmodule
